// ==== rtl/input_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : input_sync
`default_nettype wire

// ==== rtl/modulator_carrier_select.sv ====
// Data signal modulator: carrier selection, sync switching, mixing and register port
//
// Overview of operation
// - High disable bit blocks selected source pin
// - High invert bit inverts selected high carrier
// - High sync waits high falling edge
// - High select code picks carrier source
// - Low disable bit blocks selected source pin
// - Low invert bit inverts selected low carrier
// - Low sync waits low falling edge
// - Low select uses same encoding
// - Unimplemented bits ignore writes, read zero
// - Enable bit gates all mixing
// - Output invert bit inverts final output
// - Source code zero uses software bit
`timescale 1ns/1ns
`default_nettype none
module modulator_carrier_select
  import modulator_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [modulator_pkg::ADDR_W-1:0] addr,
  input  wire logic [modulator_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output var  logic [modulator_pkg::DATA_W-1:0] rdata,
  input  wire logic                      carrier_input_pin_a,
  input  wire logic                      carrier_input_pin_b,
  input  wire logic                      reference_clock,
  input  wire logic [3:0]                pwm_unit,
  input  wire logic                      source_pin,
  input  wire logic [1:0]                comparator,
  input  wire logic                      spi1_data_out,
  input  wire logic                      spi2_data_out,
  input  wire logic                      uart_tx,
  output var  logic                      mod_out,
  output var  logic                      mod_out_oe,
  output var  logic                      output_slew_limit,
  output var  logic [modulator_pkg::CAR_CODES-1:0] carrier_pin_disable,
  output var  logic [modulator_pkg::SRC_CODES-1:0] source_pin_disable
);
  import modulator_pkg::*;

  // Register state
  logic [DATA_W-1:0] modulator_control;
  logic [DATA_W-1:0] modulation_source_control;
  logic [DATA_W-1:0] high_carrier_control;
  logic [DATA_W-1:0] low_carrier_control;
  logic [DATA_W-1:0] next_modulator_control;
  logic [DATA_W-1:0] next_modulation_source_control;
  logic [DATA_W-1:0] next_high_carrier_control;
  logic [DATA_W-1:0] next_low_carrier_control;
  logic [DATA_W-1:0] next_rdata;

  // Field views
  logic             modulator_enable;
  logic             modulator_pin_output_enable;
  logic             output_invert;
  logic             software_source_bit;
  logic [SEL_W-1:0] source_select;
  logic             high_carrier_pin_disable;
  logic             high_carrier_invert;
  logic             high_carrier_sync;
  logic [SEL_W-1:0] high_carrier_select;
  logic             low_carrier_pin_disable;
  logic             low_carrier_invert;
  logic             low_carrier_sync;
  logic [SEL_W-1:0] low_carrier_select;

  assign modulator_enable            = modulator_control[BIT_ENABLE];
  assign modulator_pin_output_enable = modulator_control[BIT_PIN_OE];
  assign output_invert               = modulator_control[BIT_OUT_INVERT];
  assign software_source_bit         = modulator_control[BIT_SW_SOURCE];
  assign source_select               = modulation_source_control[SEL_MSB:0];
  assign high_carrier_pin_disable    = high_carrier_control[BIT_PIN_DISABLE];
  assign high_carrier_invert         = high_carrier_control[BIT_INVERT];
  assign high_carrier_sync           = high_carrier_control[BIT_SYNC];
  assign high_carrier_select         = high_carrier_control[SEL_MSB:0];
  assign low_carrier_pin_disable     = low_carrier_control[BIT_PIN_DISABLE];
  assign low_carrier_invert          = low_carrier_control[BIT_INVERT];
  assign low_carrier_sync            = low_carrier_control[BIT_SYNC];
  assign low_carrier_select          = low_carrier_control[SEL_MSB:0];

  // Input synchronisation
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync_in;

  assign raw_in = {uart_tx, spi2_data_out, spi1_data_out, comparator, source_pin,
                   pwm_unit, reference_clock, carrier_input_pin_b, carrier_input_pin_a};

  input_sync #(
    .WIDTH   (IN_W)
  ) u_input_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  // Register writes; masked bits never store, so they read back as zero, except control bit 3, which reads mod_out
  always_comb begin
    next_modulator_control         = modulator_control;
    next_modulation_source_control = modulation_source_control;
    next_high_carrier_control      = high_carrier_control;
    next_low_carrier_control       = low_carrier_control;
    if (wr) begin
      unique case (addr)
        OFS_CONTROL: next_modulator_control         = wdata & WMASK_CONTROL;
        OFS_SOURCE:  next_modulation_source_control = wdata & WMASK_SOURCE;
        OFS_HIGH:    next_high_carrier_control      = wdata & WMASK_CARRIER;
        OFS_LOW:     next_low_carrier_control       = wdata & WMASK_CARRIER;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      unique case (addr)
        OFS_CONTROL: begin
          next_rdata               = modulator_control;
          next_rdata[BIT_READBACK] = mod_out;
        end
        OFS_SOURCE:  next_rdata = modulation_source_control;
        OFS_HIGH:    next_rdata = high_carrier_control;
        OFS_LOW:     next_rdata = low_carrier_control;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modulator_control         <= RST_CONTROL;
      modulation_source_control <= RST_SOURCE;
      high_carrier_control      <= RST_CARRIER;
      low_carrier_control       <= RST_CARRIER;
      rdata                     <= '0;
    end else begin
      modulator_control         <= next_modulator_control;
      modulation_source_control <= next_modulation_source_control;
      high_carrier_control      <= next_high_carrier_control;
      low_carrier_control       <= next_low_carrier_control;
      rdata                     <= next_rdata;
    end
  end

  // Carrier multiplexer, shared by both selectors
  function automatic logic pick_carrier(input logic [SEL_W-1:0] sel, input logic [IN_W-1:0] in);
    logic level;
    level = 1'b0;
    if (sel == CAR_PIN_A) begin
      level = in[IN_PIN_A];
    end else if (sel == CAR_PIN_B) begin
      level = in[IN_PIN_B];
    end else if (sel == CAR_REFCLK) begin
      level = in[IN_REFCLK];
    end else if (sel >= CAR_PWM1 && sel <= CAR_LAST) begin
      level = in[IN_PWM + 32'(sel[1:0])];
    end
    return level;
  endfunction : pick_carrier

  logic high_raw;
  logic low_raw;
  logic high_level;
  logic low_level;
  logic src_level;

  assign high_raw   = pick_carrier(high_carrier_select, sync_in);
  assign low_raw    = pick_carrier(low_carrier_select, sync_in);
  assign high_level = high_raw ^ high_carrier_invert;
  assign low_level  = low_raw ^ low_carrier_invert;

  // Modulation source multiplexer
  always_comb begin
    src_level = 1'b0;
    if (source_select == SRC_SOFTWARE) begin
      src_level = software_source_bit;
    end else if (source_select == SRC_PIN) begin
      src_level = sync_in[IN_SRCPIN];
    end else if (source_select >= SRC_PWM1 && source_select < SRC_CMP1) begin
      src_level = sync_in[IN_PWM + 32'(source_select - SRC_PWM1)];
    end else if (source_select >= SRC_CMP1 && source_select < SRC_SPI1) begin
      src_level = sync_in[IN_CMP + 32'(source_select[0])];
    end else if (source_select == SRC_SPI1) begin
      src_level = sync_in[IN_SPI1];
    end else if (source_select == SRC_SPI2) begin
      src_level = sync_in[IN_SPI2];
    end else if (source_select == SRC_UART) begin
      src_level = sync_in[IN_UART];
    end
  end

  // Falling edges are taken on the processed (post-invert) carriers
  logic high_prev;
  logic low_prev;
  logic high_fall;
  logic low_fall;

  assign high_fall = high_prev & ~high_level;
  assign low_fall  = low_prev & ~low_level;

  // Carrier switching and mixing
  carrier_state_t state;
  carrier_state_t next_state;
  logic           mix_level;
  logic           next_mod_out;
  logic           next_mod_out_oe;

  always_comb begin
    next_state = state;
    if (!modulator_enable) begin
      // Disabled: track the source so enabling starts on the right carrier
      next_state = src_level ? CARRIER_HIGH : CARRIER_LOW;
    end else begin
      unique case (state)
        CARRIER_HIGH: begin
          if (!src_level && (!high_carrier_sync || high_fall)) begin
            next_state = CARRIER_LOW;
          end
        end
        CARRIER_LOW: begin
          if (src_level && (!low_carrier_sync || low_fall)) begin
            next_state = CARRIER_HIGH;
          end
        end
      endcase
    end
    mix_level       = (next_state == CARRIER_HIGH) ? high_level : low_level;
    next_mod_out    = modulator_enable & (mix_level ^ output_invert);
    next_mod_out_oe = modulator_enable & modulator_pin_output_enable;
  end

  // Peripheral pin disables, one per select code that drives a pin
  logic [CAR_CODES-1:0] next_carrier_pin_disable;
  logic [SRC_CODES-1:0] next_source_pin_disable;

  for (genvar i = 0; i < CAR_CODES; i++) begin : g_car_dis
    localparam logic [SEL_W-1:0] CODE = SEL_W'(i + 1);
    assign next_carrier_pin_disable[i] =
      (high_carrier_pin_disable && high_carrier_select == CODE) ||
      (low_carrier_pin_disable && low_carrier_select == CODE);
  end

  for (genvar j = 0; j < SRC_CODES; j++) begin : g_src_dis
    localparam logic [SEL_W-1:0] CODE = SEL_W'(j + 1);
    assign next_source_pin_disable[j] =
      modulation_source_control[BIT_PIN_DISABLE] && source_select == CODE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state               <= CARRIER_LOW;
      high_prev           <= 1'b0;
      low_prev            <= 1'b0;
      mod_out             <= 1'b0;
      mod_out_oe          <= 1'b0;
      output_slew_limit   <= 1'b0;
      carrier_pin_disable <= '0;
      source_pin_disable  <= '0;
    end else begin
      state               <= next_state;
      high_prev           <= high_level;
      low_prev            <= low_level;
      mod_out             <= next_mod_out;
      mod_out_oe          <= next_mod_out_oe;
      output_slew_limit   <= modulator_control[BIT_SLEW];
      carrier_pin_disable <= next_carrier_pin_disable;
      source_pin_disable  <= next_source_pin_disable;
    end
  end

  // Checks
  sequence high_waiting_s;
    modulator_enable && state == CARRIER_HIGH && !src_level && high_carrier_sync;
  endsequence

  sequence low_waiting_s;
    modulator_enable && state == CARRIER_LOW && src_level && low_carrier_sync;
  endsequence

  high_sync_hold_a: assert property (@(posedge clk) disable iff (rst)
    high_waiting_s ##0 !high_fall |=> state == CARRIER_HIGH)
    else $error("high carrier left before its falling edge");

  high_sync_go_a: assert property (@(posedge clk) disable iff (rst)
    high_waiting_s ##0 high_fall |=> state == CARRIER_LOW)
    else $error("high carrier falling edge did not switch");

  low_sync_hold_a: assert property (@(posedge clk) disable iff (rst)
    low_waiting_s ##0 !low_fall |=> state == CARRIER_LOW)
    else $error("low carrier left before its falling edge");

  high_nosync_a: assert property (@(posedge clk) disable iff (rst)
    (modulator_enable && state == CARRIER_HIGH && !src_level && !high_carrier_sync)
      |=> state == CARRIER_LOW)
    else $error("unsynchronised switch to low carrier missing");

  disabled_out_a: assert property (@(posedge clk) disable iff (rst)
    !modulator_enable |=> !mod_out && !mod_out_oe)
    else $error("output active while modulator disabled");

  out_polarity_a: assert property (@(posedge clk) disable iff (rst)
    (modulator_enable && state == CARRIER_LOW && !src_level)
      |=> mod_out == ($past(low_level) ^ $past(output_invert)))
    else $error("modulated output polarity wrong");

  low_sync_go_a: assert property (@(posedge clk) disable iff (rst)
    low_waiting_s ##0 low_fall |=> state == CARRIER_HIGH)
    else $error("low carrier falling edge did not switch");

  low_nosync_a: assert property (@(posedge clk) disable iff (rst)
    (modulator_enable && state == CARRIER_LOW && src_level && !low_carrier_sync)
      |=> state == CARRIER_HIGH)
    else $error("unsynchronised switch to high carrier missing");

  low_invert_a: assert property (@(posedge clk) disable iff (rst)
    low_carrier_invert |-> low_level != low_raw)
    else $error("low carrier not inverted");

  follow_high_a: assert property (@(posedge clk) disable iff (rst)
    (modulator_enable && state == CARRIER_HIGH && src_level)
      |=> mod_out == ($past(high_level) ^ $past(output_invert)))
    else $error("output does not follow high carrier");

  ground_select_a: assert property (@(posedge clk) disable iff (rst)
    (high_carrier_select == CAR_GROUND || high_carrier_select > CAR_LAST) |-> !high_raw)
    else $error("unconnected high carrier code drives a level");

  high_invert_a: assert property (@(posedge clk) disable iff (rst)
    high_carrier_invert |-> high_level != high_raw)
    else $error("high carrier not inverted");

  sw_source_a: assert property (@(posedge clk) disable iff (rst)
    source_select == SRC_SOFTWARE |-> src_level == software_source_bit)
    else $error("software source bit not used");

  high_pin_dis_a: assert property (@(posedge clk) disable iff (rst)
    (high_carrier_pin_disable && high_carrier_select == CAR_PWM1) |=> carrier_pin_disable[3])
    else $error("high carrier pin disable not applied");

  low_pin_dis_a: assert property (@(posedge clk) disable iff (rst)
    (low_carrier_pin_disable && low_carrier_select == CAR_PIN_A) |=> carrier_pin_disable[0])
    else $error("low carrier pin disable not applied");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (rd && (addr == OFS_HIGH || addr == OFS_LOW)) |=> rdata[4] == 1'b0)
    else $error("unimplemented carrier bit reads nonzero");

endmodule : modulator_carrier_select
`default_nettype wire

// ==== rtl/modulator_pkg.sv ====
// Package with register map, field positions and source codes of the modulator carrier block
package modulator_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int SEL_W  = 4;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_SOURCE  = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_HIGH    = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_LOW     = 2'h3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_SOURCE  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CARRIER = 8'h00;

  // Writable bits of each register; all others read as zero, except control bit 3 (BIT_READBACK)
  localparam logic [DATA_W-1:0] WMASK_CONTROL = 8'hF1;
  localparam logic [DATA_W-1:0] WMASK_SOURCE  = 8'h8F;
  localparam logic [DATA_W-1:0] WMASK_CARRIER = 8'hEF;

  // Control register fields
  localparam int BIT_ENABLE     = 7;
  localparam int BIT_PIN_OE     = 6;
  localparam int BIT_SLEW       = 5;
  localparam int BIT_OUT_INVERT = 4;
  localparam int BIT_READBACK   = 3;
  localparam int BIT_SW_SOURCE  = 0;

  // Carrier and source register fields
  localparam int BIT_PIN_DISABLE = 7;
  localparam int BIT_INVERT      = 6;
  localparam int BIT_SYNC        = 5;
  localparam int SEL_MSB         = 3;

  // Carrier select codes
  localparam logic [SEL_W-1:0] CAR_GROUND = 4'h0;
  localparam logic [SEL_W-1:0] CAR_PIN_A  = 4'h1;
  localparam logic [SEL_W-1:0] CAR_PIN_B  = 4'h2;
  localparam logic [SEL_W-1:0] CAR_REFCLK = 4'h3;
  localparam logic [SEL_W-1:0] CAR_PWM1   = 4'h4;
  localparam logic [SEL_W-1:0] CAR_LAST   = 4'h7;
  localparam int               CAR_CODES  = 7;

  // Modulation source select codes
  localparam logic [SEL_W-1:0] SRC_SOFTWARE = 4'h0;
  localparam logic [SEL_W-1:0] SRC_PIN      = 4'h1;
  localparam logic [SEL_W-1:0] SRC_PWM1     = 4'h2;
  localparam logic [SEL_W-1:0] SRC_CMP1     = 4'h6;
  localparam logic [SEL_W-1:0] SRC_SPI1     = 4'h8;
  localparam logic [SEL_W-1:0] SRC_SPI2     = 4'h9;
  localparam logic [SEL_W-1:0] SRC_UART     = 4'hA;
  localparam int               SRC_CODES    = 10;

  // Positions in the synchronised input vector
  localparam int IN_PIN_A  = 0;
  localparam int IN_PIN_B  = 1;
  localparam int IN_REFCLK = 2;
  localparam int IN_PWM    = 3;
  localparam int IN_SRCPIN = 7;
  localparam int IN_CMP    = 8;
  localparam int IN_SPI1   = 10;
  localparam int IN_SPI2   = 11;
  localparam int IN_UART   = 12;
  localparam int IN_W      = 13;

  typedef enum logic {
    CARRIER_LOW  = 1'b0,
    CARRIER_HIGH = 1'b1
  } carrier_state_t;

endpackage : modulator_pkg

// ==== verif/tb.sv ====
// Self-checking bench for the modulator carrier selection block
`timescale 1ns/1ns
`default_nettype none
module tb
  import modulator_pkg::*;
;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       sw;
    logic [6:0] ins;
    logic       exp;
  } row_t;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [12:0] io = 13'h0000;
  logic [7:0]  rdata;
  logic        mod_out;
  logic        mod_out_oe;
  logic        output_slew_limit;
  logic [6:0]  carrier_pin_disable;
  logic [9:0]  source_pin_disable;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          idx;

  // Carrier inputs: pin a = 0x01, pin b = 0x02, reference = 0x04, pwm units from 0x08 up
  row_t rows [16] = '{
    '{8'h01, 8'h00, 1'h1, 7'h55, 1'h1}, '{8'h02, 8'h00, 1'h1, 7'h55, 1'h0},
    '{8'h03, 8'h00, 1'h1, 7'h55, 1'h1}, '{8'h04, 8'h00, 1'h1, 7'h55, 1'h0},
    '{8'h05, 8'h00, 1'h1, 7'h2A, 1'h0}, '{8'h06, 8'h00, 1'h1, 7'h2A, 1'h1},
    '{8'h07, 8'h00, 1'h1, 7'h2A, 1'h0}, '{8'h08, 8'h00, 1'h1, 7'h7F, 1'h0},
    '{8'h00, 8'h00, 1'h1, 7'h7F, 1'h0}, '{8'h41, 8'h00, 1'h1, 7'h55, 1'h0},
    '{8'h00, 8'h02, 1'h0, 7'h2A, 1'h1}, '{8'h00, 8'h07, 1'h0, 7'h55, 1'h1},
    '{8'h00, 8'h4F, 1'h0, 7'h7F, 1'h1}, '{8'h00, 8'h43, 1'h0, 7'h55, 1'h0},
    '{8'h05, 8'h06, 1'h0, 7'h55, 1'h0}, '{8'h05, 8'h06, 1'h1, 7'h55, 1'h1}
  };

  modulator_carrier_select dut (
    .clk                 (clk),
    .rst                 (rst),
    .addr                (addr),
    .wdata               (wdata),
    .wr                  (wr),
    .rd                  (rd),
    .rdata               (rdata),
    .carrier_input_pin_a (io[0]),
    .carrier_input_pin_b (io[1]),
    .reference_clock     (io[2]),
    .pwm_unit            (io[6:3]),
    .source_pin          (io[7]),
    .comparator          (io[9:8]),
    .spi1_data_out       (io[10]),
    .spi2_data_out       (io[11]),
    .uart_tx             (io[12]),
    .mod_out             (mod_out),
    .mod_out_oe          (mod_out_oe),
    .output_slew_limit   (output_slew_limit),
    .carrier_pin_disable (carrier_pin_disable),
    .source_pin_disable  (source_pin_disable)
  );

  always #4 clk = ~clk;

  task automatic give_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Generous ceiling; the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One idle cycle after each strobe keeps the strobe from being driven twice in a step
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk("rdata", 16'(exp), 16'(rdata));
    @(posedge clk);
  endtask : rd_chk

  // Hold on carrier p (selected by sw0) must last until that carrier falls
  task automatic sync_case(input logic [7:0] h, input logic [7:0] l, input logic sw0, input int p);
    io <= 13'h0001 << p;
    wr_reg(OFS_HIGH, h);
    wr_reg(OFS_LOW, l);
    wr_reg(OFS_CONTROL, {7'h40, sw0});
    tick(6);
    chk("mod_out", 16'h0001, 16'(mod_out));
    wr_reg(OFS_CONTROL, {7'h40, ~sw0});
    tick(8);
    chk("mod_out held", 16'h0001, 16'(mod_out));
    io <= 13'h0000;
    tick(6);
    chk("mod_out after fall", 16'h0000, 16'(mod_out));
    io <= 13'h0001 << p;
    tick(6);
    chk("mod_out switched", 16'h0000, 16'(mod_out));
  endtask : sync_case

  initial begin
    tick(3);
    rst <= 1'h0;
    for (int a = 0; a < 4; a++) begin
      rd_chk(2'(a), 8'h00);
    end
    wr_reg(OFS_CONTROL, 8'h6E);
    wr_reg(OFS_SOURCE, 8'hFF);
    wr_reg(OFS_HIGH, 8'hFF);
    wr_reg(OFS_LOW, 8'hFF);
    rd_chk(OFS_CONTROL, 8'h60);
    rd_chk(OFS_SOURCE, 8'h8F);
    rd_chk(OFS_HIGH, 8'hEF);
    rd_chk(OFS_LOW, 8'hEF);
    chk("slew", 16'h0001, 16'(output_slew_limit));
    chk("oe off", 16'h0000, 16'(mod_out_oe));
    chk("mod_out disabled", 16'h0000, 16'(mod_out));
    wr_reg(OFS_SOURCE, 8'h00);
    foreach (rows[i]) begin
      io <= {6'h00, rows[i].ins};
      wr_reg(OFS_HIGH, rows[i].hi);
      wr_reg(OFS_LOW, rows[i].lo);
      wr_reg(OFS_CONTROL, {7'h40, rows[i].sw});
      tick(6);
      chk("mod_out row", 16'(rows[i].exp), 16'(mod_out));
      rd_chk(OFS_CONTROL, {4'h8, rows[i].exp, 2'h0, rows[i].sw});
    end
    // Pin disables for every carrier code, from both selectors
    for (int c = 1; c < 8; c++) begin
      wr_reg(OFS_LOW, 8'h00);
      wr_reg(OFS_HIGH, 8'h80 | 8'(c));
      tick(2);
      chk("high disable", 16'(7'h01 << (c - 1)), 16'(carrier_pin_disable));
      wr_reg(OFS_HIGH, 8'(c));
      wr_reg(OFS_LOW, 8'h80 | 8'(c));
      tick(2);
      chk("low disable", 16'(7'h01 << (c - 1)), 16'(carrier_pin_disable));
      wr_reg(OFS_LOW, 8'(c));
      tick(2);
      chk("no disable", 16'h0000, 16'(carrier_pin_disable));
    end
    // Every modulation source code from 1 to 10 against a constant-high and grounded carrier
    wr_reg(OFS_HIGH, 8'h40);
    wr_reg(OFS_LOW, 8'h00);
    wr_reg(OFS_CONTROL, 8'h80);
    for (int j = 1; j < 11; j++) begin
      idx = (j == 1) ? 7 : ((j <= 5) ? j + 1 : j + 2);
      wr_reg(OFS_SOURCE, 8'h80 | 8'(j));
      io <= 13'h0001 << idx;
      tick(6);
      chk("source disable", 16'(10'h001 << (j - 1)), 16'(source_pin_disable));
      chk("source high", 16'h0001, 16'(mod_out));
      io <= ~(13'h0001 << idx);
      tick(6);
      chk("source low", 16'h0000, 16'(mod_out));
    end
    wr_reg(OFS_SOURCE, 8'h00);
    sync_case(8'h21, 8'h00, 1'h1, 0);
    sync_case(8'h00, 8'h22, 1'h0, 1);
    // Latency through the input synchroniser
    io <= 13'h0000;
    wr_reg(OFS_HIGH, 8'h01);
    wr_reg(OFS_CONTROL, 8'h81);
    tick(6);
    io <= 13'h0001;
    tick(2);
    #1;
    chk("mod_out early", 16'h0000, 16'(mod_out));
    tick(1);
    #1;
    chk("mod_out late", 16'h0001, 16'(mod_out));
    tick(1);
    wr_reg(OFS_CONTROL, 8'h91);
    tick(6);
    chk("mod_out inverted", 16'h0000, 16'(mod_out));
    wr_reg(OFS_CONTROL, 8'hC1);
    tick(6);
    chk("oe on", 16'h0001, 16'(mod_out_oe));
    chk("mod_out plain", 16'h0001, 16'(mod_out));
    wr_reg(OFS_CONTROL, 8'h41);
    tick(6);
    chk("mod_out gated", 16'h0000, 16'(mod_out));
    chk("oe gated", 16'h0000, 16'(mod_out_oe));
    // Reset in mid-run, with the output live, clears everything
    wr_reg(OFS_CONTROL, 8'hC1);
    tick(6);
    rst <= 1'h1;
    tick(3);
    rst <= 1'h0;
    rd_chk(OFS_HIGH, 8'h00);
    rd_chk(OFS_CONTROL, 8'h00);
    chk("oe reset", 16'h0000, 16'(mod_out_oe));
    chk("mod_out reset", 16'h0000, 16'(mod_out));
    give_verdict();
  end
endmodule : tb
`default_nettype wire
